/* capacity_comp_params.svh */
// offsets, field positions, constants and reset values for the compensation datapath
`ifndef CAPACITY_COMP_PARAMS_SVH
`define CAPACITY_COMP_PARAMS_SVH
`define ADDR_INITIAL_MAX_LOAD      7'h7D
`define ADDR_DISCHARGE_COMP        7'h7E
`define ADDR_TEMP_COMP             7'h7F
`define ADDR_PACK_CONFIGURATION    7'h7C
`define ADDR_INITIAL_CAPACITY      7'h76
`define ADDR_STATUS                7'h60
`define ADDR_LEARNED_MAX_LOAD      7'h62
`define ADDR_RATE_CAP_LO           7'h64
`define ADDR_RATE_CAP_HI           7'h65
`define ADDR_TEMP_CAP_LO           7'h66
`define ADDR_TEMP_CAP_HI           7'h67
`define ADDR_FULL_CAP_LO           7'h68
`define ADDR_FULL_CAP_HI           7'h69
`define ADDR_DISCH_COMP_LO         7'h6A
`define ADDR_DISCH_COMP_HI         7'h6B
`define ADDR_TEMP_COMP_LO          7'h6C
`define ADDR_TEMP_COMP_HI          7'h6D
`define PACK_CFG_TEMP_FIX_BIT      0
`define PACK_CFG_DISCH_FIX_BIT     1
`define FIXED_DISCHARGE_COMP       8'h42
`define FIXED_TEMP_COMP            8'h7C
`define KELVIN_ZERO_C              10'h111
`define DISCH_GAIN_SHIFT           8
`define TEMP_GAIN_SHIFT            2
`define RESET_CONFIG_BYTE          8'h00
`define UNMAPPED_READ              8'h00
`endif

/* capacity_comp_pkg.sv */
// types for the capacity compensation datapath
package capacity_comp_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RATE,
        ST_TEMP
    } comp_state_t;
    typedef logic [15:0] cap_word_t;
endpackage

/* capacity_comp_sva.sv */
// assertion checker for the capacity compensation datapath ports
module capacity_comp_sva
    import capacity_comp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [6:0]  addr,
    input wire logic [7:0]  wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  rd_data,
    input wire logic        inputs_update,
    input wire logic        learn_full_capacity,
    input wire logic [15:0] learned_capacity_value,
    input wire logic [15:0] rate_compensated_capacity,
    input wire logic [15:0] temp_compensated_capacity,
    input wire logic [15:0] learned_full_capacity,
    input wire logic [15:0] learned_max_load,
    input wire logic        cold_disqualify,
    input wire logic        comp_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence take_s;
        inputs_update && !comp_busy;
    endsequence
    sequence idle3_s;
        !comp_busy [*3];
    endsequence
    chk_busy_window: assert property (take_s |=> comp_busy [*2] ##1 !comp_busy)
        else $error("busy window wrong");
    chk_rate_holds: assert property (!comp_busy ##1 !comp_busy |-> $stable(rate_compensated_capacity))
        else $error("rate capacity moved while idle");
    chk_temp_below_rate: assert property (idle3_s |-> temp_compensated_capacity <= rate_compensated_capacity)
        else $error("temp capacity above rate capacity");
    chk_learn_load: assert property (learn_full_capacity && $past(rst_n) |=> learned_full_capacity == $past(learned_capacity_value))
        else $error("full capacity not learned");
    chk_max_load_grows: assert property (1'b1 |=> learned_max_load >= $past(learned_max_load))
        else $error("max load shrank");
    chk_cold_after_take: assert property ($changed(cold_disqualify) |-> $past(comp_busy))
        else $error("cold flag moved outside compute");
    chk_unmapped_zero: assert property (rd_en && addr == 7'h00 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    chk_config_readback: assert property (wr_en && addr == 7'h7D ##1 rd_en && addr == 7'h7D |=> rd_data == $past(wr_data, 2))
        else $error("max load byte readback wrong");
endmodule
bind capacity_rate_temp_compensation capacity_comp_sva capacity_comp_sva_inst (.clk, .rst_n, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data, .inputs_update, .learn_full_capacity, .learned_capacity_value, .rate_compensated_capacity,
    .temp_compensated_capacity, .learned_full_capacity, .learned_max_load, .cold_disqualify, .comp_busy);

/* capacity_rate_temp_compensation.sv */
// discharge-rate and temperature compensation of nominal available charge
`include "capacity_comp_params.svh"

// Function
// - reset copies initial max load into learned
// - current above both learned and initial max load replaces learned max load
// - six-bit discharge gain, 0.39% per step
// - threshold code selects zero, C/2, C/4, C/8
// - discharge comp gain*(current-threshold)/256, nonnegative
// - rate capacity subtracts comp excess over reference
// - learning full capacity latches comp reference
// - pack bit1 forces discharge constants 0x42
// - four-bit temperature gain in upper nibble
// - offset nibble is kelvin minus 273
// - temp comp gain*capacity*(273+off-T)/4, nonnegative
// - temp capacity is rate capacity minus comp
// - pack bit0 forces temperature constants 0x7C
// - full capacity high byte initial, low zero
module capacity_rate_temp_compensation
    import capacity_comp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register bus
    input  wire logic [6:0]  addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rd_data,
    // compute inputs
    input  wire logic [15:0] average_current,
    input  wire logic [9:0]  temperature_kelvin,
    input  wire logic [15:0] nominal_available_charge,
    input  wire logic        inputs_update,
    input  wire logic        learn_full_capacity,
    input  wire logic [15:0] learned_capacity_value,
    // results
    output logic      [15:0] rate_compensated_capacity,
    output logic      [15:0] temp_compensated_capacity,
    output logic      [15:0] learned_full_capacity,
    output logic      [15:0] learned_max_load,
    output logic             cold_disqualify,
    output logic             comp_busy
);

    logic [7:0]  initial_max_load_reg;
    logic [7:0]  discharge_comp_constants_reg;
    logic [7:0]  temp_comp_constants_reg;
    logic [7:0]  pack_configuration_reg;
    logic [7:0]  initial_capacity_byte_reg;
    logic [15:0] discharge_compensation_reg;
    logic [15:0] temperature_compensation_reg;
    logic [15:0] learned_comp_reference_reg;
    logic [15:0] avg_current_reg;
    logic [9:0]  temperature_reg;
    logic [15:0] charge_reg;
    logic        startup_reg;
    comp_state_t state_reg;

    logic [7:0]  disch_constants;
    logic [7:0]  temp_constants;
    logic [5:0]  discharge_gain;
    logic [1:0]  discharge_threshold;
    logic [3:0]  temperature_gain;
    logic [3:0]  temperature_offset;
    logic [15:0] threshold_value;
    logic [15:0] discharge_compensation_next;
    logic [15:0] temperature_compensation_next;
    logic [15:0] rate_capacity_next;
    logic [15:0] temp_capacity_next;
    logic [9:0]  temp_limit;

    // saturating subtract, floor at zero
    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        sat_sub = (a > b) ? a - b : 16'h0000;
    endfunction

    // clamp a wide product to sixteen bits
    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (v[31:16] != 16'h0000) ? 16'hFFFF : v[15:0];
    endfunction

    // fixed constants substitute stored bytes
    assign disch_constants = pack_configuration_reg[`PACK_CFG_DISCH_FIX_BIT]
                             ? `FIXED_DISCHARGE_COMP : discharge_comp_constants_reg;
    assign temp_constants  = pack_configuration_reg[`PACK_CFG_TEMP_FIX_BIT]
                             ? `FIXED_TEMP_COMP : temp_comp_constants_reg;
    assign discharge_gain      = disch_constants[7:2];
    assign discharge_threshold = disch_constants[1:0];
    assign temperature_gain    = temp_constants[7:4];
    assign temperature_offset  = temp_constants[3:0];
    assign temp_limit = `KELVIN_ZERO_C + {6'h00, temperature_offset};

    // threshold is initial capacity times 256, halved once, twice or three times by the code, or zero
    always_comb
    begin
        case (discharge_threshold)
            2'h0:    threshold_value = 16'h0000;
            2'h1:    threshold_value = {1'b0, initial_capacity_byte_reg, 7'h00};
            2'h2:    threshold_value = {2'h0, initial_capacity_byte_reg, 6'h00};
            default: threshold_value = {3'h0, initial_capacity_byte_reg, 5'h00};
        endcase
    end

    always_comb
    begin
        logic [15:0] excess;
        logic [31:0] prod;
        excess = sat_sub(avg_current_reg, threshold_value);
        prod = ({16'h0000, excess} * {26'h0, discharge_gain}) >> `DISCH_GAIN_SHIFT;
        discharge_compensation_next = sat16(prod);
    end

    always_comb
    begin
        logic [9:0]  delta;
        logic [31:0] prod;
        delta = (temp_limit > temperature_reg) ? temp_limit - temperature_reg : 10'h000;
        // three small fields, product stays well inside 32 bits
        prod = ({28'h0, temperature_gain} * {24'h0, initial_capacity_byte_reg} * {22'h0, delta})
               >> `TEMP_GAIN_SHIFT;
        temperature_compensation_next = sat16(prod);
    end

    assign rate_capacity_next = (discharge_compensation_reg > learned_comp_reference_reg)
        ? sat_sub(charge_reg, discharge_compensation_reg - learned_comp_reference_reg)
        : charge_reg;
    assign temp_capacity_next = sat_sub(rate_compensated_capacity, temperature_compensation_reg);

    // configuration registers written by software
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            initial_max_load_reg         <= `RESET_CONFIG_BYTE;
            discharge_comp_constants_reg <= `RESET_CONFIG_BYTE;
            temp_comp_constants_reg      <= `RESET_CONFIG_BYTE;
            pack_configuration_reg       <= `RESET_CONFIG_BYTE;
            initial_capacity_byte_reg    <= `RESET_CONFIG_BYTE;
        end
        else if (wr_en)
        begin
            case (addr)
                `ADDR_INITIAL_MAX_LOAD:   initial_max_load_reg         <= wr_data;
                `ADDR_DISCHARGE_COMP:     discharge_comp_constants_reg <= wr_data;
                `ADDR_TEMP_COMP:          temp_comp_constants_reg      <= wr_data;
                `ADDR_PACK_CONFIGURATION: pack_configuration_reg       <= wr_data;
                `ADDR_INITIAL_CAPACITY:   initial_capacity_byte_reg    <= wr_data;
                default:                  ;
            endcase
        end
    end

    // input capture and compute sequence
    // one pass: capture, compensations, rate capacity
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg       <= ST_IDLE;
            avg_current_reg <= 16'h0000;
            temperature_reg <= 10'h000;
            charge_reg      <= 16'h0000;
            comp_busy       <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (inputs_update)
                    begin
                        avg_current_reg <= average_current;
                        temperature_reg <= temperature_kelvin;
                        charge_reg      <= nominal_available_charge;
                        state_reg       <= ST_RATE;
                        comp_busy       <= 1'b1;
                    end
                end
                ST_RATE:
                begin
                    state_reg <= ST_TEMP;
                end
                ST_TEMP:
                begin
                    state_reg <= ST_IDLE;
                    comp_busy <= 1'b0;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // compensation results
    // temp capacity tracks rate capacity while idle, so a
    // changed temp compensation shows the cycle after comp_busy drops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            discharge_compensation_reg   <= 16'h0000;
            temperature_compensation_reg <= 16'h0000;
            rate_compensated_capacity    <= 16'h0000;
            temp_compensated_capacity    <= 16'h0000;
            cold_disqualify              <= 1'b0;
        end
        else if (state_reg == ST_RATE)
        begin
            discharge_compensation_reg   <= discharge_compensation_next;
            temperature_compensation_reg <= temperature_compensation_next;
            cold_disqualify              <= temperature_reg < temp_limit;
        end
        else if (state_reg == ST_TEMP)
        begin
            rate_compensated_capacity <= rate_capacity_next;
        end
        else if (state_reg == ST_IDLE && comp_busy == 1'b0)
        begin
            temp_compensated_capacity <= temp_capacity_next;
        end
    end

    // learned full capacity and its compensation reference
    // startup cycle reloads from config bytes; a learn pulse
    // in that cycle is dropped so the reload always lands
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            startup_reg                <= 1'b1;
            learned_full_capacity      <= 16'h0000;
            learned_comp_reference_reg <= 16'h0000;
        end
        else if (startup_reg)
        begin
            startup_reg           <= 1'b0;
            learned_full_capacity <= {initial_capacity_byte_reg, 8'h00};
        end
        else if (learn_full_capacity)
        begin
            learned_full_capacity      <= learned_capacity_value;
            learned_comp_reference_reg <= discharge_compensation_reg;
        end
    end

    // learned maximum load
    // only currents above the configured load may replace it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            learned_max_load <= 16'h0000;
        end
        else if (startup_reg)
        begin
            learned_max_load <= {8'h00, initial_max_load_reg};
        end
        else if (state_reg == ST_RATE && avg_current_reg > {8'h00, initial_max_load_reg}
                 && avg_current_reg > learned_max_load)
        begin
            learned_max_load <= avg_current_reg;
        end
    end

    // register read port, data one cycle after strobe
    // 16-bit values have no snapshot: read high, low, high
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_data <= `UNMAPPED_READ;
        end
        else if (rd_en)
        begin
            case (addr)
                `ADDR_INITIAL_MAX_LOAD:   rd_data <= initial_max_load_reg;
                `ADDR_DISCHARGE_COMP:     rd_data <= discharge_comp_constants_reg;
                `ADDR_TEMP_COMP:          rd_data <= temp_comp_constants_reg;
                `ADDR_PACK_CONFIGURATION: rd_data <= pack_configuration_reg;
                `ADDR_INITIAL_CAPACITY:   rd_data <= initial_capacity_byte_reg;
                `ADDR_STATUS:             rd_data <= {6'h00, cold_disqualify, comp_busy};
                `ADDR_LEARNED_MAX_LOAD:   rd_data <= learned_max_load[7:0];
                `ADDR_RATE_CAP_LO:        rd_data <= rate_compensated_capacity[7:0];
                `ADDR_RATE_CAP_HI:        rd_data <= rate_compensated_capacity[15:8];
                `ADDR_TEMP_CAP_LO:        rd_data <= temp_compensated_capacity[7:0];
                `ADDR_TEMP_CAP_HI:        rd_data <= temp_compensated_capacity[15:8];
                `ADDR_FULL_CAP_LO:        rd_data <= learned_full_capacity[7:0];
                `ADDR_FULL_CAP_HI:        rd_data <= learned_full_capacity[15:8];
                `ADDR_DISCH_COMP_LO:      rd_data <= discharge_compensation_reg[7:0];
                `ADDR_DISCH_COMP_HI:      rd_data <= discharge_compensation_reg[15:8];
                `ADDR_TEMP_COMP_LO:       rd_data <= temperature_compensation_reg[7:0];
                `ADDR_TEMP_COMP_HI:       rd_data <= temperature_compensation_reg[15:8];
                default:                  rd_data <= `UNMAPPED_READ;
            endcase
        end
    end

endmodule

/* capacity_rate_temp_compensation_bench.sv */
// self-checking bench for the capacity compensation datapath
module capacity_rate_temp_compensation_bench
    import capacity_comp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic      clk, rst_n, wr_en, rd_en, inputs_update, learn_full_capacity, cold_disqualify, comp_busy;
    logic [6:0] addr;
    logic [7:0] wr_data, rd_data, v, hi;
    logic [9:0] temperature_kelvin;
    cap_word_t average_current, nominal_available_charge, learned_capacity_value, learned_full_capacity;
    cap_word_t rate_compensated_capacity, temp_compensated_capacity, learned_max_load, mx, ref_v, discharge_comp_constants_exp;
    int        n_fail, cmp_count;
    localparam logic [7:0] DC [7] = '{8'h00, 8'h48, 8'h49, 8'hFE, 8'h07, 8'hFF, 8'h4B};
    localparam logic [7:0] TC [7] = '{8'h00, 8'h35, 8'hF0, 8'h2A, 8'h1F, 8'hFF, 8'h00};
    localparam logic [7:0] PK [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01};
    localparam cap_word_t CUR [7] = '{16'h0050, 16'h0C00, 16'h0900, 16'h0500, 16'h0100, 16'h0800, 16'h0C00};
    localparam cap_word_t NC [7] = '{16'h0100, 16'h3000, 16'h2000, 16'h1000, 16'h0800, 16'h0050, 16'h0400};
    localparam int        TK [7] = '{300, 270, 273, 280, 300, 280, 280};

    capacity_rate_temp_compensation capacity_rate_temp_compensation_inst (.clk, .rst_n, .addr, .wr_data, .wr_en,
        .rd_en, .rd_data, .average_current, .temperature_kelvin, .nominal_available_charge, .inputs_update,
        .learn_full_capacity, .learned_capacity_value, .rate_compensated_capacity, .temp_compensated_capacity,
        .learned_full_capacity, .learned_max_load, .cold_disqualify, .comp_busy);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run;
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(cap_word_t seen, cap_word_t exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // the write strobe stays up for back-to-back writes; the next action drops it
    task automatic wr(logic [6:0] a, logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(logic [6:0] a, output logic [7:0] d);
        addr <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic run(int i, cap_word_t a);
        int thr, d, rate, tcm;
        logic [7:0] dv, tv;
        dv = PK[i][1] ? 8'h42 : DC[i];
        tv = PK[i][0] ? 8'h7C : TC[i];
        wr(7'h7E, DC[i]);
        wr(7'h7F, TC[i]);
        wr(7'h7C, PK[i]);
        wr_en <= 1'b0;
        average_current <= a;
        temperature_kelvin <= 10'(TK[i]);
        nominal_available_charge <= NC[i];
        inputs_update <= 1'b1;
        @(posedge clk);
        inputs_update <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        thr = dv[1:0] == 2'b00 ? 0 : 4096 >> dv[1:0];
        discharge_comp_constants_exp = 16'(dv[7:2] * (a > thr ? a - thr : 0) / 256);
        rate = discharge_comp_constants_exp > ref_v ? NC[i] - (discharge_comp_constants_exp - ref_v) : NC[i];
        rate = rate < 0 ? 0 : rate;
        d = 273 + tv[3:0] - TK[i];
        tcm = d > 0 ? tv[7:4] * 16 * d / 4 : 0;
        mx = (a > 16'h0080 && a > mx) ? a : mx;
        chk(rate_compensated_capacity, 16'(rate));
        chk(temp_compensated_capacity, 16'(rate > tcm ? rate - tcm : 0));
        chk(16'(cold_disqualify), 16'(d > 0));
        chk(learned_max_load, mx);
        wr(7'h64, 8'hA5);
        rd(7'h65, hi);
        rd(7'h64, v);
        chk({hi, v}, 16'(rate));
    endtask

    initial
    begin
        #400000;
        n_fail++;
        complete_run;
    end

    initial
    begin
        {rst_n, wr_en, rd_en, inputs_update, learn_full_capacity} = '0;
        {addr, wr_data, temperature_kelvin} = '0;
        {average_current, nominal_available_charge, learned_capacity_value, mx, ref_v} = '0;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(learned_full_capacity, 16'h0000);
        chk(learned_max_load, 16'h0000);
        rd(7'h7D, v);
        chk(16'(v), 16'h0000);
        wr(7'h7D, 8'h80);
        rd(7'h7D, v);
        chk(16'(v), 16'h0080);
        rd(7'h00, v);
        chk(16'(v), 16'h0000);
        wr(7'h76, 8'h10);
        for (int i = 0; i < 7; i++)
            run(i, CUR[i]);
        learned_capacity_value <= 16'h1234;
        learn_full_capacity <= 1'b1;
        @(posedge clk);
        learn_full_capacity <= 1'b0;
        #1;
        chk(learned_full_capacity, 16'h1234);
        ref_v = discharge_comp_constants_exp;
        run(6, 16'h0C00);
        run(6, 16'h0D00);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(learned_full_capacity, 16'h0000);
        chk(learned_max_load, 16'h0000);
        complete_run;
    end
endmodule
